// ===== hdl/timer16_compare_output_normal_ctc.v
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "timer16_map.vh"

// Operation
// - Counter write blocks compare matches in the next timer tick, even when stopped.
// - Counter written equal to variable top ignores that top match; counts to 0xFFFF.
// - Compare output state keeps its value when the waveform mode changes.
// - Output action field is not buffered; new setting acts at once.
// - System reset clears compare output state to zero.
// - Nonzero action field makes compare output replace port value; direction unchanged.
// - Compare output reaches pin only when pin direction selects output.
// - Output action field has no influence on capture logic.
// - Action field zero leaves compare output unchanged at a match.
// - Action applies at next match; force strobe applies it immediately in non-PWM.
// - Count sequence depends on waveform mode only; action field drives outputs only.
// - Mode 0 always increments, rolling from 0xFFFF to 0x0000.
// - Normal mode sets overflow flag when counter becomes zero; hardware only sets.
// - Clear-on-match clears counter at top: compare A in mode 4, capture in 12.
// - Clear-on-match signals top by compare A flag or capture flag accordingly.
// - Top unbuffered; top below counter means run to 0xFFFF, wrap, then match.
// - Clear-on-match with action 1 toggles compare output A on each match.
// - Toggle frequency is io clock over 2*N*(1+compare A); top at zero is fastest.
// - Prescale factor selectable among 1, 8, 64, 256 and 1024.
// - Clear-on-match sets overflow flag when counter passes max to 0x0000, except when top is 0xFFFF.
// - Force strobe updates output like a match, no flag, no counter change.
// - Equality sets compare flag next timer tick; cleared by ack or writing one.
module timer16_compare_output_normal_ctc #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_n,
  // Register port
  input wire [3:0] reg_addr,
  input wire [WIDTH-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [WIDTH-1:0] reg_rdata,
  // Interrupt acknowledges
  input wire ovf_ack,
  input wire cmpa_ack,
  input wire cmpb_ack,
  input wire cap_ack,
  // Capture event from capture unit
  input wire capture_event,
  input wire [WIDTH-1:0] capture_sample,
  // Port pins
  input wire port_out_a,
  input wire port_out_b,
  input wire pin_direction_bit_a,
  input wire pin_direction_bit_b,
  output reg pin_out_a,
  output reg pin_out_b,
  output reg pin_oe_n_a,
  output reg pin_oe_n_b,
  // Flags
  output reg overflow_flag,
  output reg compare_flag_a,
  output reg compare_flag_b,
  output reg capture_flag
);

  // ==========================================
  // Registers
  reg [WIDTH-1:0] counter_value_r;
  reg [WIDTH-1:0] compare_value_a_r;
  reg [WIDTH-1:0] compare_value_b_r;
  reg [WIDTH-1:0] capture_value_r;
  reg [10:0] ctrl_r;
  reg [9:0] div_r;
  reg block_r;
  reg compare_output_a_r;
  reg compare_output_b_r;

  wire [3:0] waveform_mode_field = ctrl_r[`CTRL_WGM_HI:`CTRL_WGM_LO];
  wire [1:0] output_action_field_a = ctrl_r[`CTRL_COMA_HI:`CTRL_COMA_LO];
  wire [1:0] output_action_field_b = ctrl_r[`CTRL_COMB_HI:`CTRL_COMB_LO];
  wire [2:0] clk_sel = ctrl_r[`CTRL_CS_HI:`CTRL_CS_LO];
  wire is_normal = (waveform_mode_field == `WGM_NORMAL);
  wire is_ctc_a = (waveform_mode_field == `WGM_CTC_A);
  wire is_ctc_cap = (waveform_mode_field == `WGM_CTC_CAP);
  wire non_pwm = is_normal | is_ctc_a | is_ctc_cap;

  // ==========================================
  // Prescaler tick
  reg tick;
  always @* begin
    case (clk_sel)
      3'h1: tick = 1'b1;
      3'h2: tick = ({7'h00, div_r[2:0]} == `DIV_8);
      3'h3: tick = ({4'h0, div_r[5:0]} == `DIV_64);
      3'h4: tick = ({2'h0, div_r[7:0]} == `DIV_256);
      3'h5: tick = (div_r == `DIV_1024);
      default: tick = 1'b0;
    endcase
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 10'h000;
    end else if (clk_sel == 3'h0) begin
      div_r <= 10'h000;
    end else begin
      div_r <= div_r + 10'h001;
    end
  end

  // ==========================================
  // Compare and count
  wire wr_cnt = reg_wr && (reg_addr == `ADDR_COUNTER);
  wire wr_force = reg_wr && (reg_addr == `ADDR_FORCE);
  wire wr_flags = reg_wr && (reg_addr == `ADDR_FLAGS);
  wire match_a = (counter_value_r == compare_value_a_r) && !block_r;
  wire match_b = (counter_value_r == compare_value_b_r) && !block_r;
  wire match_cap = (counter_value_r == capture_value_r) && !block_r;
  wire at_top = is_ctc_a ? match_a : (is_ctc_cap ? match_cap : 1'b0);
  reg [WIDTH-1:0] cnt_nxt;
  always @* begin
    if (at_top) begin
      cnt_nxt = `CNT_BOTTOM;
    end else begin
      cnt_nxt = counter_value_r + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
  wire wrap = (counter_value_r == `CNT_MAX) && !at_top;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      counter_value_r <= `CNT_BOTTOM;
      block_r <= 1'b0;
    end else if (wr_cnt) begin
      counter_value_r <= reg_wdata;
      block_r <= 1'b1;
    end else if (tick) begin
      counter_value_r <= cnt_nxt;
      block_r <= 1'b0;
    end
  end

  // ==========================================
  // Output action
  function next_out;
    input [1:0] act;
    input cur;
    begin
      case (act)
        2'h1: next_out = ~cur;
        2'h2: next_out = 1'b0;
        2'h3: next_out = 1'b1;
        default: next_out = cur;
      endcase
    end
  endfunction

  wire force_a = wr_force && reg_wdata[0] && non_pwm;
  wire force_b = wr_force && reg_wdata[1] && non_pwm;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      compare_output_a_r <= 1'b0;
      compare_output_b_r <= 1'b0;
    end else begin
      if (force_a || (tick && match_a && non_pwm)) begin
        compare_output_a_r <= next_out(output_action_field_a, compare_output_a_r);
      end
      if (force_b || (tick && match_b && non_pwm)) begin
        compare_output_b_r <= next_out(output_action_field_b, compare_output_b_r);
      end
    end
  end

  // ==========================================
  // Pins
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out_a <= 1'b0;
      pin_out_b <= 1'b0;
      pin_oe_n_a <= 1'b1;
      pin_oe_n_b <= 1'b1;
    end else begin
      pin_out_a <= (output_action_field_a != 2'h0) ? compare_output_a_r : port_out_a;
      pin_out_b <= (output_action_field_b != 2'h0) ? compare_output_b_r : port_out_b;
      pin_oe_n_a <= ~pin_direction_bit_a;
      pin_oe_n_b <= ~pin_direction_bit_b;
    end
  end

  // ==========================================
  // Flags
  wire set_ovf = tick && wrap;
  wire set_a = tick && match_a;
  wire set_b = tick && match_b;
  wire set_cap = (tick && is_ctc_cap && match_cap) || (capture_event && !is_ctc_cap);

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      overflow_flag <= 1'b0;
      compare_flag_a <= 1'b0;
      compare_flag_b <= 1'b0;
      capture_flag <= 1'b0;
    end else begin
      if (set_ovf) begin
        overflow_flag <= 1'b1;
      end else if (ovf_ack || (wr_flags && reg_wdata[`FLG_OVF])) begin
        overflow_flag <= 1'b0;
      end
      if (set_a) begin
        compare_flag_a <= 1'b1;
      end else if (cmpa_ack || (wr_flags && reg_wdata[`FLG_CMPA])) begin
        compare_flag_a <= 1'b0;
      end
      if (set_b) begin
        compare_flag_b <= 1'b1;
      end else if (cmpb_ack || (wr_flags && reg_wdata[`FLG_CMPB])) begin
        compare_flag_b <= 1'b0;
      end
      if (set_cap) begin
        capture_flag <= 1'b1;
      end else if (cap_ack || (wr_flags && reg_wdata[`FLG_CAP])) begin
        capture_flag <= 1'b0;
      end
    end
  end

  // ==========================================
  // Register writes and reads
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      compare_value_a_r <= `CNT_BOTTOM;
      compare_value_b_r <= `CNT_BOTTOM;
      capture_value_r <= `CNT_BOTTOM;
      ctrl_r <= `CTRL_RESET;
    end else begin
      if (reg_wr && reg_addr == `ADDR_COMPARE_A) begin
        compare_value_a_r <= reg_wdata;
      end
      if (reg_wr && reg_addr == `ADDR_COMPARE_B) begin
        compare_value_b_r <= reg_wdata;
      end
      if (reg_wr && reg_addr == `ADDR_CAPTURE && is_ctc_cap) begin
        capture_value_r <= reg_wdata;
      end else if (capture_event && !is_ctc_cap) begin
        capture_value_r <= capture_sample;
      end
      if (reg_wr && reg_addr == `ADDR_CTRL) begin
        ctrl_r <= reg_wdata[10:0];
      end
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= {WIDTH{1'b0}};
    end else if (reg_rd) begin
      case (reg_addr)
        `ADDR_COUNTER: reg_rdata <= counter_value_r;
        `ADDR_COMPARE_A: reg_rdata <= compare_value_a_r;
        `ADDR_COMPARE_B: reg_rdata <= compare_value_b_r;
        `ADDR_CAPTURE: reg_rdata <= capture_value_r;
        `ADDR_CTRL: reg_rdata <= {5'h00, ctrl_r};
        `ADDR_FLAGS: reg_rdata <= {10'h000, compare_output_b_r, compare_output_a_r,
                                   capture_flag, compare_flag_b, compare_flag_a, overflow_flag};
        default: reg_rdata <= {WIDTH{1'b0}};
      endcase
    end else begin
      reg_rdata <= {WIDTH{1'b0}};
    end
  end

endmodule // timer16_compare_output_normal_ctc

// ===== shared/timer16_map.vh
`ifndef TIMER16_MAP_VH
`define TIMER16_MAP_VH
// ==========================================
// Register offsets
`define ADDR_COUNTER 4'h0
`define ADDR_COMPARE_A 4'h1
`define ADDR_COMPARE_B 4'h2
`define ADDR_CAPTURE 4'h3
`define ADDR_CTRL 4'h4
`define ADDR_FLAGS 4'h5
`define ADDR_FORCE 4'h6
// ==========================================
// Control field positions
`define CTRL_WGM_LO 0
`define CTRL_WGM_HI 3
`define CTRL_COMA_LO 4
`define CTRL_COMA_HI 5
`define CTRL_COMB_LO 6
`define CTRL_COMB_HI 7
`define CTRL_CS_LO 8
`define CTRL_CS_HI 10
// ==========================================
// Flag positions
`define FLG_OVF 0
`define FLG_CMPA 1
`define FLG_CMPB 2
`define FLG_CAP 3
// ==========================================
// Modes and values
`define WGM_NORMAL 4'h0
`define WGM_CTC_A 4'h4
`define WGM_CTC_CAP 4'hC
`define CNT_MAX 16'hFFFF
`define CNT_BOTTOM 16'h0000
`define CTRL_RESET 11'h000
`define DIV_8 10'h007
`define DIV_64 10'h03F
`define DIV_256 10'h0FF
`define DIV_1024 10'h3FF
`endif

// ===== test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  reg ref_clk = 1'b0;
  reg rst_n = 1'b0;
  reg [3:0] reg_addr = 4'h0;
  reg [15:0] reg_wdata = 16'h0000;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [3:0] ack = 4'h0;
  reg cap_ev = 1'b0;
  reg [15:0] cap_smp = 16'h1234;
  reg [1:0] port_out = 2'h0;
  reg [1:0] dir = 2'h0;
  wire [15:0] reg_rdata;
  wire [1:0] pin_out;
  wire [1:0] oe_n;
  wire [3:0] flg;
  integer failures = 0;
  integer checked = 0;
  integer i, n, t;
  reg [15:0] d;
  reg [1:0] ac;
  reg st;
  timer16_compare_output_normal_ctc #(.WIDTH(16)) i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ovf_ack(ack[0]),
    .cmpa_ack(ack[1]), .cmpb_ack(ack[2]), .cap_ack(ack[3]), .capture_event(cap_ev),
    .capture_sample(cap_smp), .port_out_a(port_out[0]), .port_out_b(port_out[1]),
    .pin_direction_bit_a(dir[0]), .pin_direction_bit_b(dir[1]), .pin_out_a(pin_out[0]),
    .pin_out_b(pin_out[1]), .pin_oe_n_a(oe_n[0]), .pin_oe_n_b(oe_n[1]),
    .overflow_flag(flg[0]), .compare_flag_a(flg[1]), .compare_flag_b(flg[2]),
    .capture_flag(flg[3]));
  // ==========================================
  // Tasks
  task chk(input [63:0] nm, input [15:0] e, input [15:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("ERROR %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task wr(input [3:0] a, input [15:0] v);
    begin
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      #1;
    end
  endtask
  task rd(input [3:0] a);
    begin
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
    end
  endtask
  task pulse(input [3:0] m);
    begin
      @(posedge ref_clk);
      ack <= m;
      @(posedge ref_clk);
      ack <= 4'h0;
      repeat (2) @(posedge ref_clk);
    end
  endtask
  task wait_flag(input integer b, input integer lim);
    begin
      n = 0;
      while (flg[b] !== 1'b1 && n < lim) begin
        @(posedge ref_clk);
        #1 n = n + 1;
      end
      if (n >= lim) begin
        failures = failures + 1;
        report_and_stop;
      end
    end
  endtask
  task top_chk(input [15:0] lim);
    for (t = 0; t < 6; t = t + 1) begin
      rd(4'h0);
      chk("top", 16'h0001, {15'h0, d <= lim});
    end
  endtask
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  // ==========================================
  // Sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(4'h5);
    chk("flags", 16'h0000, d);
    rd(4'hF);
    chk("unmap", 16'h0000, d);
    $display("reset test done");
    port_out <= 2'h1;
    st = 1'b0;
    for (i = 0; i < 5; i = i + 1) begin
      ac = 10'h079 >> (2 * i);
      wr(4'h4, {10'h000, ac, 4'h0});
      wr(4'h6, 16'h0001);
      dir <= 2'h3;
      st = (ac == 2'h1) ? ~st : (ac == 2'h0) ? st : ac[0];
      rd(4'h5);
      chk("out_a", {15'h0, st}, {15'h0, d[4]});
      chk("pin_a", {15'h0, (ac != 2'h0) ? st : 1'b1}, {15'h0, pin_out[0]});
      chk("oe_n", 16'h0000, {15'h0, oe_n[0]});
    end
    rd(4'h0);
    chk("cnt", 16'h0000, d);
    wr(4'h4, 16'h00C4);
    wr(4'h6, 16'h0002);
    rd(4'h5);
    chk("keep_a", {15'h0, st}, {15'h0, d[4]});
    chk("pin_b", 16'h0001, {15'h0, pin_out[1]});
    $display("force test done");
    wr(4'h4, 16'h0000);
    wr(4'h1, 16'h0020);
    wr(4'h0, 16'h0020);
    wr(4'h4, 16'h0100);
    repeat (10) @(posedge ref_clk);
    #1 chk("blk", 16'h0000, {15'h0, flg[1]});
    wr(4'h0, 16'hFFF0);
    wait_flag(0, 40);
    rd(4'h0);
    chk("wrap", 16'h0001, {15'h0, d < 16'h0030});
    wr(4'h4, 16'h0000);
    wr(4'h5, 16'h0004);
    chk("clr_b", 16'h0000, {15'h0, flg[2]});
    pulse(4'h1);
    chk("ovf", 16'h0000, {15'h0, flg[0]});
    $display("normal test done");
    wr(4'h1, 16'h0003);
    wr(4'h0, 16'h0000);
    wr(4'h5, 16'h000F);
    wr(4'h4, 16'h0114);
    wait_flag(1, 20);
    st = pin_out[0];
    n = 0;
    for (i = 0; i < 40; i = i + 1) begin
      @(posedge ref_clk);
      #1 n = n + (pin_out[0] !== st);
      st = pin_out[0];
    end
    chk("tgl", 16'h000A, n[15:0]);
    top_chk(16'h0003);
    chk("no_ovf", 16'h0000, {15'h0, flg[0]});
    wr(4'h4, 16'h0014);
    pulse(4'h2);
    chk("ack_a", 16'h0000, {15'h0, flg[1]});
    wr(4'h0, 16'h000A);
    wr(4'h4, 16'h0114);
    wait_flag(0, 70000);
    chk("miss", 16'h0000, {15'h0, flg[1]});
    wr(4'h4, 16'h000C);
    wr(4'h3, 16'h0005);
    wr(4'h5, 16'h000F);
    wr(4'h4, 16'h010C);
    wait_flag(3, 20);
    top_chk(16'h0005);
    $display("ctc test done");
    wr(4'h4, 16'h0130);
    wr(4'h5, 16'h0008);
    chk("clr_cap", 16'h0000, {15'h0, flg[3]});
    @(posedge ref_clk);
    cap_ev <= 1'b1;
    @(posedge ref_clk);
    cap_ev <= 1'b0;
    wait_flag(3, 10);
    rd(4'h3);
    chk("cap", 16'h1234, d);
    $display("capture test done");
    report_and_stop;
  end
endmodule // tb_top

// ===== test/timer16_chk_sva.sv
`timescale 1ns/1ps
module timer16_chk #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_n,
  // Register port
  input wire [3:0] reg_addr,
  input wire [WIDTH-1:0] reg_wdata,
  input wire reg_wr,
  // Acknowledges
  input wire ovf_ack,
  input wire cmpa_ack,
  input wire cmpb_ack,
  // Pin A
  input wire port_out_a,
  input wire pin_direction_bit_a,
  input wire pin_out_a,
  input wire pin_oe_n_a,
  // Flags
  input wire overflow_flag,
  input wire compare_flag_a,
  input wire compare_flag_b
);
  // ==========================================
  // Control shadow
  reg [10:0] ctrl_r;
  reg [1:0] up_r;
  wire [3:0] w1c = reg_wdata[3:0] & {4{reg_wr && reg_addr == 4'h5}};
  wire run = |ctrl_r[10:8];
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= 11'h000;
      up_r <= 2'h0;
    end else begin
      if (reg_wr && reg_addr == 4'h4) ctrl_r <= reg_wdata[10:0];
      if (up_r != 2'h3) up_r <= up_r + 2'h1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Properties
  property p_oe_a;
    up_r == 2'h3 |-> pin_oe_n_a == !$past(pin_direction_bit_a);
  endproperty
  a_oe_a: assert property (p_oe_a) else $error("pin A enable wrong");
  property p_pass_a;
    up_r == 2'h3 && $past(ctrl_r[5:4]) == 2'h0 && $past(pin_direction_bit_a)
      |-> pin_out_a == $past(port_out_a);
  endproperty
  a_pass_a: assert property (p_pass_a) else $error("pin A not port value");
  property p_ovf;
    $fell(overflow_flag) |-> $past(ovf_ack) || $past(w1c[0]);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag cleared");
  property p_cmpa;
    $fell(compare_flag_a) |-> $past(cmpa_ack) || $past(w1c[1]);
  endproperty
  a_cmpa: assert property (p_cmpa) else $error("compare A flag cleared");
  property p_cmpb;
    $fell(compare_flag_b) |-> $past(cmpb_ack) || $past(w1c[2]);
  endproperty
  a_cmpb: assert property (p_cmpb) else $error("compare B flag cleared");
  property p_stop_ovf;
    up_r == 2'h3 && !$past(run) && !$past(run, 2) |-> !$rose(overflow_flag);
  endproperty
  a_stop_ovf: assert property (p_stop_ovf) else $error("overflow while stopped");
  property p_stop_a;
    up_r == 2'h3 && !$past(run) && !$past(run, 2) |-> !$rose(compare_flag_a);
  endproperty
  a_stop_a: assert property (p_stop_a) else $error("compare A while stopped");
  property p_stop_b;
    up_r == 2'h3 && !$past(run) && !$past(run, 2) |-> !$rose(compare_flag_b);
  endproperty
  a_stop_b: assert property (p_stop_b) else $error("compare B while stopped");
endmodule // timer16_chk

bind timer16_compare_output_normal_ctc timer16_chk #(.WIDTH(WIDTH)) u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .ovf_ack(ovf_ack), .cmpa_ack(cmpa_ack), .cmpb_ack(cmpb_ack),
  .port_out_a(port_out_a), .pin_direction_bit_a(pin_direction_bit_a),
  .pin_out_a(pin_out_a), .pin_oe_n_a(pin_oe_n_a), .overflow_flag(overflow_flag),
  .compare_flag_a(compare_flag_a), .compare_flag_b(compare_flag_b));
